// ===== tb/hmac_ctrl_reg_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// checker: register port and decode
// ----------------------------------------
module hmac_ctrl_reg_properties
    import hmac_pkg::*;
(
    input  wire logic       I_CORE_CLK,  // system clock
    input  wire logic       I_ARST_N,    // async reset
    input  wire logic [15:0] I_IO_ADDR,  // port address
    input  wire logic       I_IO_WR,     // write strobe
    input  wire logic       I_IO_RD,     // read strobe
    input  wire logic [7:0] I_IO_WDATA,  // write data
    input  wire logic [7:0] O_IO_RDATA,  // read data
    input  wire logic       O_IO_RD_HIT, // read claimed
    input  wire hmac_req_t  I_MEM_REQ,   // memory request
    input  wire logic [1:0] I_MAP_SEL,   // window select
    input  wire hmac_dec_t  O_DEC,       // decode result
    input  wire hmac_ctrl_t O_CTRL,      // decoded control
    input  wire logic       O_PIN_OE     // pin drive enable
);
    logic [7:0] idx_r;     // shadow of the index port
    logic [7:0] shadow_r;  // shadow of the control register
    logic       rd_ok;     // read aimed at the control register
    assign rd_ok = I_IO_RD && I_IO_ADDR == HMAC_DATA_PORT && idx_r == HMAC_IDX_CTRL_TWO;
    // shadow follows writes so outputs can be judged without a read
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            idx_r    <= 8'h00;
            shadow_r <= HMAC_CTRL_RESET;
        end else if (I_IO_WR && I_IO_ADDR == HMAC_INDEX_PORT) begin
            idx_r <= I_IO_WDATA;
        end else if (I_IO_WR && I_IO_ADDR == HMAC_DATA_PORT && idx_r == HMAC_IDX_CTRL_TWO) begin
            shadow_r <= I_IO_WDATA;
        end
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);
    sequence s_rd_req;
        rd_ok;
    endsequence
    sequence s_legacy_req;
        I_MEM_REQ.valid && I_MEM_REQ.addr >= 32'h000A0000 && I_MEM_REQ.addr <= 32'h000AFFFF;
    endsequence
    property p_rd_answer;
        s_rd_req |=> O_IO_RD_HIT && O_IO_RDATA == $past(shadow_r);
    endproperty
    property p_rd_refuse;
        !rd_ok |=> !O_IO_RD_HIT && O_IO_RDATA == 8'h00;
    endproperty
    property p_path_wide;
        shadow_r[4] |-> O_CTRL.path_64;
    endproperty
    property p_path_narrow;
        !shadow_r[4] && !shadow_r[2] |-> !O_CTRL.path_64;
    endproperty
    property p_path_mdp;
        !shadow_r[4] && shadow_r[2] |-> O_CTRL.path_64;
    endproperty
    property p_wrap;
        O_CTRL.wrap_256k == (shadow_r[4:3] == 2'b00 && !shadow_r[2]);
    endproperty
    property p_fields;
        O_CTRL.rotate_en == shadow_r[1] && O_CTRL.linear == shadow_r[0]
            && O_CTRL.single_ap == (shadow_r[0] && shadow_r[5])
            && O_CTRL.clkrun_en == shadow_r[6] && O_PIN_OE == shadow_r[7];
    endproperty
    property p_bank_hit;
        s_legacy_req ##0 (!shadow_r[0] && I_MAP_SEL == 2'b01) |=> O_DEC.hit && O_DEC.via_bank;
    endproperty
    property p_single;
        s_legacy_req ##0 (shadow_r[0] && shadow_r[5]) |=> !O_DEC.via_bank;
    endproperty
    a_rd_answer:   assert property (p_rd_answer) else $error("read answer wrong");
    a_rd_refuse:   assert property (p_rd_refuse) else $error("foreign read claimed");
    a_path_wide:   assert property (p_path_wide) else $error("packed mode not wide");
    a_path_narrow: assert property (p_path_narrow) else $error("narrow mode wide");
    a_path_mdp:    assert property (p_path_mdp) else $error("wide path select ignored");
    a_wrap:        assert property (p_wrap) else $error("wrap wrong");
    a_fields:      assert property (p_fields) else $error("control field wrong");
    a_bank_hit:    assert property (p_bank_hit) else $error("banked window missed");
    a_single:      assert property (p_single) else $error("legacy window in single aperture");
endmodule
bind hmac_ctrl_reg hmac_ctrl_reg_properties u_props (.I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N),
    .I_IO_ADDR(I_IO_ADDR), .I_IO_WR(I_IO_WR), .I_IO_RD(I_IO_RD), .I_IO_WDATA(I_IO_WDATA),
    .O_IO_RDATA(O_IO_RDATA), .O_IO_RD_HIT(O_IO_RD_HIT), .I_MEM_REQ(I_MEM_REQ), .I_MAP_SEL(I_MAP_SEL),
    .O_DEC(O_DEC), .O_CTRL(O_CTRL), .O_PIN_OE(O_PIN_OE));

// ===== tb/hmac_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host cpu on the sequencer i/o ports
// ----------------------------------------
module hmac_host_model
    import hmac_pkg::*;
(
    input  wire logic  i_clk,   // system clock
    output logic [15:0] o_addr, // port address
    output logic       o_wr,    // write strobe
    output logic       o_rd,    // read strobe
    output logic [7:0] o_wdata  // write data
);
    initial begin
        o_addr  = 16'h0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 8'h00;
    end
    // one strobe cycle; released lines show the inverse so stale values never look valid
    task automatic io_cycle(input logic [15:0] port, input logic wr, input logic [7:0] data);
        @(posedge i_clk); #1;
        o_addr = port; o_wr = wr; o_rd = !wr; o_wdata = data;
        @(posedge i_clk); #1;
        o_wr = 1'b0; o_rd = 1'b0; o_addr = ~port; o_wdata = ~data;
    endtask
    // index first, then the data port
    task automatic reg_write(input logic [7:0] idx, input logic [7:0] data);
        io_cycle(HMAC_INDEX_PORT, 1'b1, idx);
        io_cycle(HMAC_DATA_PORT, 1'b1, data);
    endtask
    // answer stands from return until the next clock edge
    task automatic reg_read(input logic [7:0] idx);
        io_cycle(HMAC_INDEX_PORT, 1'b1, idx);
        io_cycle(HMAC_DATA_PORT, 1'b0, 8'h00);
    endtask
    // software opens the whole display memory in narrow modes
    task automatic full_range(input logic [7:0] cur);
        reg_write(HMAC_IDX_CTRL_TWO, (cur | 8'h04) & 8'hEF);
    endtask
endmodule

// ===== tb/host_memory_aperture_control_tb.sv
`timescale 1ns/1ps
module host_memory_aperture_control_tb;
    import hmac_pkg::*;
    logic clk, arst_n, io_wr, io_rd, rd_hit, pin, pin_oe, clkrun_req, pin_out;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, rdata, bank;
    logic [1:0]  map_sel;
    logic [31:0] lin_base, lin_mask;
    hmac_req_t   mem_req;
    hmac_dec_t   dec;
    hmac_ctrl_t  ctrl;
    int          miscompares = 0, compares = 0, cycles = 0;
    logic [7:0]  vals [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h12, 8'h19, 8'h40, 8'hC3, 8'hFF};
    hmac_host_model host (.i_clk(clk), .o_addr(io_addr), .o_wr(io_wr), .o_rd(io_rd), .o_wdata(io_wdata));
    hmac_ctrl_reg DUT (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_IO_ADDR(io_addr), .I_IO_WR(io_wr),
        .I_IO_RD(io_rd), .I_IO_WDATA(io_wdata), .O_IO_RDATA(rdata), .O_IO_RD_HIT(rd_hit),
        .I_MEM_REQ(mem_req), .I_MAP_SEL(map_sel), .I_BANK(bank), .I_LIN_BASE(lin_base),
        .I_LIN_SIZE_MASK(lin_mask), .I_CLKRUN_PIN(pin), .O_DEC(dec), .O_CTRL(ctrl),
        .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_CLKRUN_REQ(clkrun_req));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        if (miscompares == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one decode sample; an expected offset of all ones skips the offset
    task automatic mem(input logic [31:0] a, input logic [1:0] m, input logic h, input logic b, input logic [31:0] o);
        @(posedge clk); #1;
        mem_req = '{valid: 1'b1, addr: a};
        map_sel = m;
        @(posedge clk); #1;
        mem_req.valid = 1'b0;
        chk("hit", {31'h0, h}, {31'h0, dec.hit});
        chk("via_bank", {31'h0, b}, {31'h0, dec.via_bank});
        if (o != 32'hFFFFFFFF) chk("offset", o, dec.offset);
    endtask
    task automatic t_modes();
        logic [7:0] v;
        foreach (vals[i]) begin
            v = vals[i];
            host.reg_write(HMAC_IDX_CTRL_TWO, v);
            host.reg_read(HMAC_IDX_CTRL_TWO);
            chk("readback", {24'h0, v}, {24'h0, rdata});
            chk("fields", {25'h0, v[0], v[0] & v[5], v[4] | v[2], v[4:3] == 2'b00 && !v[2], v[1], v[6], v[7]},
                {25'h0, ctrl});
            chk("pin drive enable", {31'h0, v[7]}, {31'h0, pin_oe});
        end
        host.full_range(8'h10);
        chk("full range wrap", 32'h0, {31'h0, ctrl.wrap_256k});
        chk("full range path", 32'h1, {31'h0, ctrl.path_64});
    endtask
    task automatic t_refuse();
        host.reg_write(8'h17, 8'h5A);
        host.reg_read(8'h17);
        chk("foreign hit", 32'h0, {31'h0, rd_hit});
        chk("foreign data", 32'h0, {24'h0, rdata});
        host.reg_read(HMAC_IDX_CTRL_TWO);
        chk("kept value", 32'h04, {24'h0, rdata});
    endtask
    task automatic t_decode();
        host.reg_write(HMAC_IDX_CTRL_TWO, 8'h00);
        mem(32'h000B1234, 2'b00, 1'b1, 1'b1, 32'h00011234);
        mem(32'h000AFFFF, 2'b01, 1'b1, 1'b1, 32'h0001FFFF);
        mem(32'h000B7000, 2'b10, 1'b1, 1'b1, 32'h00017000);
        mem(32'h000BFFFF, 2'b11, 1'b1, 1'b1, 32'h00017FFF);
        mem(32'h000B0000, 2'b01, 1'b0, 1'b0, 32'hFFFFFFFF);
        mem(32'h010B1234, 2'b00, 1'b0, 1'b0, 32'hFFFFFFFF);
        host.reg_write(HMAC_IDX_CTRL_TWO, 8'h08);
        mem(32'h000A0010, 2'b01, 1'b1, 1'b1, 32'h00050010);
        host.reg_write(HMAC_IDX_CTRL_TWO, 8'h01);
        mem(32'h08001234, 2'b01, 1'b1, 1'b0, 32'h00001234);
        mem(32'h09000000, 2'b01, 1'b0, 1'b0, 32'hFFFFFFFF);
        mem(32'h000A0010, 2'b01, 1'b1, 1'b1, 32'hFFFFFFFF);
        host.reg_write(HMAC_IDX_CTRL_TWO, 8'h21);
        mem(32'h000A0010, 2'b01, 1'b0, 1'b0, 32'hFFFFFFFF);
    endtask
    task automatic t_pin();
        host.reg_write(HMAC_IDX_CTRL_TWO, 8'h40);
        pin = 1'b0;
        repeat (3) @(posedge clk); #1;
        chk("clkrun low pin", 32'h1, {31'h0, clkrun_req});
        pin = 1'b1;
        repeat (3) @(posedge clk); #1;
        chk("clkrun high pin", 32'h0, {31'h0, clkrun_req});
        host.reg_write(HMAC_IDX_CTRL_TWO, 8'hC0);
        pin = 1'b0;
        repeat (3) @(posedge clk); #1;
        chk("clkrun as output", 32'h0, {31'h0, clkrun_req});
        chk("pin drive", 32'h1, {31'h0, pin_oe});
        mem_req.valid = 1'b1;
        @(posedge clk); #1;
        chk("activity out", 32'h1, {31'h0, pin_out});
        mem_req.valid = 1'b0;
        @(posedge clk); #1;
        chk("activity idle", 32'h0, {31'h0, pin_out});
    endtask
    // reset in mid-run brings the register back to its power-on value
    task automatic t_reset();
        host.reg_write(HMAC_IDX_CTRL_TWO, 8'hFF);
        arst_n = 1'b0;
        repeat (2) @(posedge clk); #1;
        arst_n = 1'b1;
        chk("reset fields", 32'h08, {25'h0, ctrl});
        chk("reset pin drive", 32'h0, {31'h0, pin_oe});
        host.reg_read(HMAC_IDX_CTRL_TWO);
        chk("reset value again", 32'h0, {24'h0, rdata});
    endtask
    // main sequence
    initial begin
        arst_n = 1'b0;
        pin = 1'b1;
        bank = 8'h05;
        map_sel = 2'b00;
        lin_base = 32'h08000000;
        lin_mask = 32'h003FFFFF;
        mem_req = '0;
        repeat (5) @(posedge clk); #1;
        arst_n = 1'b1;
        host.reg_read(HMAC_IDX_CTRL_TWO);
        chk("reset value", 32'h0, {24'h0, rdata});
        t_modes();
        t_refuse();
        t_decode();
        t_pin();
        t_reset();
        close_out();
    end
endmodule

// ===== verilog/hmac_ctrl_reg.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module hmac_ctrl_reg
    import hmac_pkg::*;
#(
    parameter int ADDR_W = 32,                      // host address width
    parameter int BANK_W = 8                        // bank select width
)(
    input  wire logic              I_CORE_CLK,      // system clock
    input  wire logic              I_ARST_N,        // async reset, active low
    input  wire logic [15:0]       I_IO_ADDR,       // host i/o port address
    input  wire logic              I_IO_WR,         // i/o write strobe
    input  wire logic              I_IO_RD,         // i/o read strobe
    input  wire logic [7:0]        I_IO_WDATA,      // i/o write data
    output logic [7:0]             O_IO_RDATA,      // i/o read data, registered
    output logic                   O_IO_RD_HIT,     // read claimed by this register
    input  wire hmac_req_t         I_MEM_REQ,       // host memory request
    input  wire logic [1:0]        I_MAP_SEL,       // graphics-controller index 6 bits 3:2
    input  wire logic [BANK_W-1:0] I_BANK,          // bank_select_register value
    input  wire logic [ADDR_W-1:0] I_LIN_BASE,      // linear base from PCI BAR
    input  wire logic [ADDR_W-1:0] I_LIN_SIZE_MASK, // aperture size minus one
    input  wire logic              I_CLKRUN_PIN,    // shared pin input level
    output hmac_dec_t              O_DEC,           // registered decode result
    output hmac_ctrl_t             O_CTRL,          // decoded control fields
    output logic                   O_PIN_OUT,       // shared pin output level
    output logic                   O_PIN_OE,        // shared pin drive enable
    output logic                   O_CLKRUN_REQ     // synchronised clock-run request
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 24 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie in 24..32");
    end
    if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank
        $error("BANK_W must lie in 1..8");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  index;        // sequencer index latch
        logic [7:0]  ctrl;         // graphics_command_control_two
        logic [7:0]  rdata;        // read data
        logic        rd_hit;       // read claimed
        hmac_dec_t   dec;          // decode result
        logic [1:0]  pin_sync;     // two-flop synchroniser of the pin
        logic        pin_act;      // registered activity output level
    } hmac_state_t;
    // all state lives in one record so reset and the register stage stay in one place;
    // the decode result is registered, which costs one cycle of latency on every access

    hmac_state_t st_r;             // registered state
    hmac_state_t st_nxt;           // next state

    logic        win_hit;          // banked window hit
    logic [23:0] win_base;         // banked window base
    hmac_ctrl_t  ctl;              // field decode
    hmac_mode_t  mode;             // graphics mode field

    hmac_window_decode u_win (
        .i_map_sel (I_MAP_SEL),
        .i_addr    (I_MEM_REQ.addr[23:0]),
        .o_hit     (win_hit),
        .o_base    (win_base)
    );

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    // the wide-path bit only matters in the 32-bit modes, so 1x ignores it
    always_comb begin
        mode          = hmac_mode_t'(st_r.ctrl[HMAC_BIT_MODE_HI:HMAC_BIT_MODE_LO]);
        ctl.linear    = st_r.ctrl[HMAC_BIT_LINEAR];
        ctl.single_ap = ctl.linear & st_r.ctrl[HMAC_BIT_SINGLE];
        ctl.rotate_en = st_r.ctrl[HMAC_BIT_ROTATE];
        ctl.clkrun_en = st_r.ctrl[HMAC_BIT_CLKRUN];
        ctl.pin_is_out = st_r.ctrl[HMAC_BIT_PIN_SEL];
        // the mode field picks the data path width and the wrap:
        //   00  standard, 32-bit path, wraps at 256 KB
        //   01  planar 16-colour, 32-bit path, no wrap
        //   1x  packed pixel, always the full 64-bit path
        // in the two narrow modes the wide-path bit lifts the 32-bit limit, in 00 the wrap as well,
        // which is how software reaches all of display memory there
        case (mode)
            HMAC_MODE_VGA: begin
                // standard mode: narrow and wrapped unless software opens full range
                ctl.path_64   = st_r.ctrl[HMAC_BIT_WIDE];
                ctl.wrap_256k = ~st_r.ctrl[HMAC_BIT_WIDE];
            end
            HMAC_MODE_PLANAR: begin
                // planar mode never wraps; the wide bit still widens the path
                ctl.path_64   = st_r.ctrl[HMAC_BIT_WIDE];
                ctl.wrap_256k = 1'b0;
            end
            default: begin
                // packed pixel modes: the wide bit has no effect here
                ctl.path_64   = 1'b1;
                ctl.wrap_256k = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic        lin_hit;      // inside linear aperture
        logic        use_bank;     // route through the legacy window
        logic        win_ok;       // legacy window hit in the first megabyte
        logic [31:0] off;          // computed offset
        st_nxt   = st_r;
        lin_hit  = 1'b0;
        use_bank = 1'b0;
        // the legacy windows sit below 1 MB; without the upper-bit test any
        // address whose low 24 bits fall in a window would alias into it
        win_ok   = win_hit && (I_MEM_REQ.addr[31:24] == 8'h00);
        off      = 32'h0000_0000;

        // index port latch
        if (I_IO_WR && I_IO_ADDR == HMAC_INDEX_PORT) begin
            st_nxt.index = I_IO_WDATA;
        end
        // data port write of our index
        if (I_IO_WR && I_IO_ADDR == HMAC_DATA_PORT && st_r.index == HMAC_IDX_CTRL_TWO) begin
            st_nxt.ctrl = I_IO_WDATA;
        end
        // read returns the whole register, no reserved bits
        st_nxt.rd_hit = I_IO_RD && I_IO_ADDR == HMAC_DATA_PORT && st_r.index == HMAC_IDX_CTRL_TWO;
        st_nxt.rdata  = st_nxt.rd_hit ? st_r.ctrl : 8'h00;

        // memory decode
        lin_hit = ((I_MEM_REQ.addr & ~32'(I_LIN_SIZE_MASK)) == 32'(I_LIN_BASE));
        // priority: banked mode uses only the legacy window; in linear mode the linear
        // aperture wins, and the A0000 window is a fallback in dual aperture only
        if (!ctl.linear) begin
            // banked: window plus bank register gives the offset
            use_bank = win_ok;
            off      = {8'h00, 24'(I_MEM_REQ.addr[23:0] - win_base)}
                     | {8'h00, 8'(I_BANK), 16'h0000};
        end else if (lin_hit) begin
            off = I_MEM_REQ.addr & 32'(I_LIN_SIZE_MASK);
        end else if (!ctl.single_ap && win_ok && I_MAP_SEL == 2'b01) begin
            // dual aperture keeps A0000-AFFFF alive beside the linear one
            use_bank = 1'b1;
            off      = {8'h00, 24'(I_MEM_REQ.addr[23:0] - win_base)};
        end
        if (ctl.wrap_256k) begin
            off = off & {8'h00, HMAC_WRAP_MASK};
        end
        st_nxt.dec.hit      = I_MEM_REQ.valid & (use_bank | (ctl.linear & lin_hit));
        st_nxt.dec.via_bank = I_MEM_REQ.valid & use_bank;
        st_nxt.dec.offset   = I_MEM_REQ.valid ? off : 32'h0000_0000;

        // pin synchroniser, first flop only feeds the second
        st_nxt.pin_sync = {st_r.pin_sync[0], I_CLKRUN_PIN};
        // the synchronised level starts at zero after reset; harmless, because
        // clock-run stays disabled until software sets bit 6
        // activity level follows a live request while the pin is an output
        st_nxt.pin_act  = ctl.pin_is_out & I_MEM_REQ.valid;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_r       <= '0;
            st_r.ctrl  <= HMAC_CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the pin is driven only as an activity output; as input it feeds clock-run
    assign O_IO_RDATA   = st_r.rdata;
    assign O_IO_RD_HIT  = st_r.rd_hit;
    assign O_DEC        = st_r.dec;
    assign O_CTRL       = ctl;
    assign O_PIN_OE     = ctl.pin_is_out;
    // control fields are decoded straight from the register, so a write reaches
    // the memory path on the very next edge; read data, decode and activity
    // level all leave from flip-flops
    assign O_PIN_OUT    = st_r.pin_act;
    assign O_CLKRUN_REQ = ctl.clkrun_en & ~ctl.pin_is_out & ~st_r.pin_sync[1];

endmodule

// ===== verilog/hmac_pkg.sv
package hmac_pkg;

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    localparam logic [15:0] HMAC_DATA_PORT     = 16'h03C5;    // sequencer data port
    localparam logic [15:0] HMAC_INDEX_PORT    = 16'h03C4;    // sequencer index port
    localparam logic [7:0]  HMAC_IDX_CTRL_TWO  = 8'h18;       // graphics_command_control_two index
    localparam logic [7:0]  HMAC_CTRL_RESET    = 8'h00;       // power-on value

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HMAC_BIT_LINEAR   = 0;   // linear_addressing_enable
    localparam int HMAC_BIT_ROTATE   = 1;   // repeat_rotation_blit_enable
    localparam int HMAC_BIT_WIDE     = 2;   // wide_path_select
    localparam int HMAC_BIT_MODE_LO  = 3;   // graphics mode low bit
    localparam int HMAC_BIT_MODE_HI  = 4;   // graphics mode high bit
    localparam int HMAC_BIT_SINGLE   = 5;   // aperture_single_select
    localparam int HMAC_BIT_CLKRUN   = 6;   // clock_run_enable
    localparam int HMAC_BIT_PIN_SEL  = 7;   // shared pin direction

    // ------------------------------------------------------------
    // address windows, byte addresses of the host memory space
    // ------------------------------------------------------------
    localparam logic [23:0] HMAC_WIN_A0000   = 24'h0A0000;
    localparam logic [23:0] HMAC_WIN_AFFFF   = 24'h0AFFFF;
    localparam logic [23:0] HMAC_WIN_B0000   = 24'h0B0000;
    localparam logic [23:0] HMAC_WIN_B7000   = 24'h0B7000;
    localparam logic [23:0] HMAC_WIN_B8000   = 24'h0B8000;
    localparam logic [23:0] HMAC_WIN_BFFFF   = 24'h0BFFFF;
    localparam logic [23:0] HMAC_WRAP_MASK   = 24'h03FFFF;  // 256 KB wrap

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HMAC_MODE_VGA    = 2'b00,
        HMAC_MODE_PLANAR = 2'b01,
        HMAC_MODE_PACK0  = 2'b10,
        HMAC_MODE_PACK1  = 2'b11
    } hmac_mode_t;

    // decoded control carried to the memory path
    typedef struct packed {
        logic        linear;        // linear addressing selected
        logic        single_ap;     // only the linear aperture decodes
        logic        path_64;       // full 64-bit internal path
        logic        wrap_256k;     // wrap address at 256 KB
        logic        rotate_en;     // repeat rotation blit enabled
        logic        clkrun_en;     // clock-run function enabled
        logic        pin_is_out;    // shared pin drives activity
    } hmac_ctrl_t;

    // one host memory access request
    typedef struct packed {
        logic        valid;         // request present
        logic [31:0] addr;          // host byte address
    } hmac_req_t;

    // result of the decode
    typedef struct packed {
        logic        hit;           // the device claims the access
        logic        via_bank;      // address comes from the bank window
        logic [31:0] offset;        // offset into display memory
    } hmac_dec_t;

endpackage

// ===== verilog/hmac_window_decode.sv
`timescale 1ns/1ps
// combinational banked-window decode
module hmac_window_decode
    import hmac_pkg::*;
(
    input  wire logic [1:0]  i_map_sel,    // graphics-controller index 6 bits 3:2
    input  wire logic [23:0] i_addr,       // low host address bits
    output logic             o_hit,        // address inside the selected window
    output logic [23:0]      o_base        // window base address
);

    // ------------------------------------------------------------
    // window select
    // ------------------------------------------------------------
    // window bounds follow the map select; the 10 range ends at B7000 inclusive
    always_comb begin
        case (i_map_sel)
            2'b00: begin
                o_hit  = (i_addr >= HMAC_WIN_A0000) && (i_addr <= HMAC_WIN_BFFFF);
                o_base = HMAC_WIN_A0000;
            end
            2'b01: begin
                o_hit  = (i_addr >= HMAC_WIN_A0000) && (i_addr <= HMAC_WIN_AFFFF);
                o_base = HMAC_WIN_A0000;
            end
            2'b10: begin
                o_hit  = (i_addr >= HMAC_WIN_B0000) && (i_addr <= HMAC_WIN_B7000);
                o_base = HMAC_WIN_B0000;
            end
            default: begin
                o_hit  = (i_addr >= HMAC_WIN_B8000) && (i_addr <= HMAC_WIN_BFFFF);
                o_base = HMAC_WIN_B8000;
            end
        endcase
    end

endmodule
